/* File: design/hub_port_power_pin_control.sv */
`timescale 1ns/100ps
// How it works
// (RL1) reset pin low clears all core state except warm, which stays 2'b11; the pin synchronisers keep running
// (RL2) power select low means bus powered, high means self powered
// (RL3) mode pin stays input after reset so the strap can be read
// (RL4) gang strap: later drive pin low in normal, high in suspend
// (RL5) individual strap: later drive pin high in normal operation
// (RL6) individual strap: drive pin low while globally suspended
// (RL7) test select low is normal, high enters test mode
// (RL8) port power enable output is active low by default
// (RL9) shared power/eeprom pin serves one function only
// (RL10) with eeprom present the shared pin stays the data line
// (RL11) outside switches pull a port's overcurrent input low
// (RL12) gang mode acts on port 1 overcurrent only
// (RL13) mode strap is sampled within 20 us after reset
// (RL14) pin becomes output 50 to 60 ms after reset; suspend shown
module hub_port_power_pin_control
  import hub_pin_pkg::*;
#(
  parameter int STRAP_AT = STRAP_AT_CYC,
  parameter int OUT_AT   = OUT_AT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              reset_n,
  input  wire logic              power_source_select,
  input  wire logic              test_select,
  input  wire logic              mode_pin_in,
  output logic                   mode_pin_out,
  output logic                   mode_pin_oe_n,
  input  wire logic [NPORT-1:0]  overcurrent_n,
  input  wire logic              share_pin_in,
  output logic                   port_power_enable_n,
  output logic                   share_pin_oe_n,
  output logic                   eeprom_sda_in,
  input  wire logic              eeprom_sda_out,
  input  wire logic              eeprom_sda_oe_n,
  input  wire logic              global_suspend,
  output logic                   self_powered,
  output logic                   test_mode,
  output logic                   gang_mode,
  output logic [NPORT-1:0]       port_overcurrent,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SW = NPORT + 5;
  logic [SW-1:0] pins_s;
  logic          rst_pin_s;
  logic          psel_s;
  logic          test_s;
  logic          mode_s;
  logic [NPORT-1:0] ovc_s;
  logic          share_s;

  // pins with pull-ups read as high through reset, hence these idle levels
  pin_sync #(
    .W (SW)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .d       ({share_pin_in, overcurrent_n, mode_pin_in, test_select,
               power_source_select, reset_n}),
    .rst_val ({1'b1, {NPORT{1'b1}}, 1'b0, 1'b0, 1'b0, 1'b1}),
    .q       (pins_s)
  );

  assign rst_pin_s = pins_s[0];
  assign psel_s    = pins_s[1];
  assign test_s    = pins_s[2];
  assign mode_s    = pins_s[3];
  assign ovc_s     = pins_s[4 +: NPORT];
  assign share_s   = pins_s[SW-1];

  // synchronised pin reads high for two edges after rst; warm holds the pin reset off for three
  logic pin_reset_seen;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    phase_t             phase;
    logic [31:0]        cnt;
    logic               gang;
    logic               pin_out_en;
    logic               self_pwr;
    logic               test;
    logic               susp_d;
    logic [NPORT-1:0]   ovc;
    logic [NPORT-1:0]   ovc_d;
    logic [2:0]         ctrl;
    logic [IRQ_W-1:0]   stat;
    logic [IRQ_W-1:0]   mask;
    logic [DATA_W-1:0]  rdata;
    logic [1:0]         warm;
  } core_t;

  core_t st_ff;
  core_t nxt_st;

  // reads status bits packed into one word
  function automatic logic [DATA_W-1:0] status_word(input core_t s);
    status_word = '0;
    status_word[0]           = s.self_pwr;
    status_word[1]           = s.test;
    status_word[2]           = s.gang;
    status_word[3]           = s.pin_out_en;
    status_word[4 +: NPORT]  = s.ovc;
    status_word[8 +: 2]      = s.phase;
  endfunction

  assign pin_reset_seen = (st_ff.warm == 2'b11) && !rst_pin_s;

  logic             eeprom_present;
  logic [NPORT-1:0] ovc_live;
  logic [IRQ_W-1:0] events;
  logic             susp_now;

  assign eeprom_present = st_ff.ctrl[CTRL_EEPROM];
  assign susp_now       = global_suspend | st_ff.ctrl[CTRL_SUSPEND];

  // gang mode masks ports 2..4; their pins are simply not looked at
  always_comb begin
    ovc_live = ~ovc_s;                                    // [RL11]
    if (st_ff.gang) begin
      ovc_live[NPORT-1:1] = '0;                           // [RL12]
    end
  end

  assign events = {susp_now & ~st_ff.susp_d, ovc_live & ~st_ff.ovc_d};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = '0;
    if (ce) begin
      if (st_ff.warm != 2'b11) begin
        nxt_st.warm = st_ff.warm + 2'd1;
      end
      nxt_st.self_pwr = psel_s;                           // [RL2]
      nxt_st.test     = test_s;                           // [RL7]
      nxt_st.ovc      = ovc_live;
      nxt_st.ovc_d    = ovc_live;
      nxt_st.susp_d   = susp_now;
      nxt_st.cnt      = st_ff.cnt + 32'd1;

      unique case (st_ff.phase)
        PH_STRAP: begin
          nxt_st.pin_out_en = 1'b0;                       // [RL3]
          if (st_ff.cnt == 32'(STRAP_AT)) begin
            nxt_st.gang  = mode_s;                        // [RL13]
            nxt_st.phase = PH_WAIT;
          end
        end
        PH_WAIT: begin
          if (st_ff.cnt == 32'(OUT_AT)) begin
            nxt_st.pin_out_en = 1'b1;                     // [RL14]
            nxt_st.phase      = PH_RUN;
          end
        end
        PH_RUN: begin
          nxt_st.cnt = st_ff.cnt;
        end
        // unused phase code: restart the strap window
        default: begin
          nxt_st.phase = PH_STRAP;
          nxt_st.cnt   = '0;
        end
      endcase

      // sticky status: set wins over write-one-to-clear
      if (wr && addr == REG_IRQ) begin
        nxt_st.stat = st_ff.stat & ~wdata[IRQ_W-1:0];
      end
      nxt_st.stat = nxt_st.stat | events;

      if (wr && addr == REG_CTRL) begin
        nxt_st.ctrl = wdata[2:0];
      end
      if (wr && addr == REG_MASK) begin
        nxt_st.mask = wdata[IRQ_W-1:0];
      end

      if (rd) begin
        unique case (addr)
          REG_CTRL:   nxt_st.rdata = DATA_W'(st_ff.ctrl);
          REG_STATUS: nxt_st.rdata = status_word(st_ff);
          REG_IRQ:    nxt_st.rdata = DATA_W'(st_ff.stat);
          REG_MASK:   nxt_st.rdata = DATA_W'(st_ff.mask);
          REG_ID:     nxt_st.rdata = ID_VALUE;
          default:    nxt_st.rdata = '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers; once synchronised the reset pin clears the core state like rst, but loads warm with 2'b11
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (pin_reset_seen) begin
      st_ff      <= '0;                                   // [RL1]
      st_ff.warm <= 2'b11;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic mode_level;

  // gang: low normal, high suspend; individual: high normal, low suspend
  always_comb begin
    if (st_ff.gang) begin
      mode_level = susp_now;                              // [RL4]
    end else begin
      mode_level = !susp_now;                             // [RL5] [RL6]
    end
  end

  assign mode_pin_out  = mode_level;
  assign mode_pin_oe_n = !st_ff.pin_out_en;               // [RL3] [RL14]

  // shared pin: either eeprom data or power enable, never both
  always_comb begin
    if (eeprom_present) begin
      port_power_enable_n = eeprom_sda_out;               // [RL10]
      share_pin_oe_n      = eeprom_sda_oe_n;
      eeprom_sda_in       = share_s;
    end else begin
      port_power_enable_n = !st_ff.ctrl[CTRL_PWR_ON];     // [RL8]
      share_pin_oe_n      = 1'b0;                         // [RL9]
      eeprom_sda_in       = 1'b1;
    end
  end

  assign self_powered     = st_ff.self_pwr;
  assign test_mode        = st_ff.test;
  assign gang_mode        = st_ff.gang;
  assign port_overcurrent = st_ff.ovc;
  assign rdata            = st_ff.rdata;
  assign irq              = |(st_ff.stat & st_ff.mask);
endmodule

/* File: design/hub_pin_pkg.sv */
package hub_pin_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int STRAP_WIN_NS    = 20_000;      // strap sampled within 20 us
  localparam int OUT_MIN_MS      = 50;          // pin turns output 50..60 ms
  localparam int OUT_MAX_MS      = 60;
  localparam int STRAP_CYC       = (STRAP_WIN_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int OUT_MIN_CYC     = OUT_MIN_MS * (CLK_HZ / 1000);
  localparam int OUT_MAX_CYC     = OUT_MAX_MS * (CLK_HZ / 1000);
  // strap is taken halfway into the window, output at midpoint
  localparam int STRAP_AT_CYC    = STRAP_CYC / 2;
  localparam int OUT_AT_CYC      = (OUT_MIN_CYC + OUT_MAX_CYC) / 2;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int ADDR_W          = 4;
  localparam int DATA_W          = 32;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ    = 4'h2;
  localparam logic [3:0] REG_MASK   = 4'h3;
  localparam logic [3:0] REG_ID     = 4'h4;

  // ctrl fields
  localparam int CTRL_SUSPEND    = 0;
  localparam int CTRL_PWR_ON     = 1;
  localparam int CTRL_EEPROM     = 2;

  // irq bit positions: 0..3 overcurrent per port, 4 suspend entered
  localparam int NPORT           = 4;
  localparam int IRQ_W           = 5;
  localparam int IRQ_SUSP        = 4;

  localparam logic [31:0] ID_VALUE = 32'h0000_1234;  // arbitrary value

  typedef enum logic [1:0] {PH_STRAP, PH_WAIT, PH_RUN} phase_t;

endpackage

/* File: design/pin_sync.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// two-stage synchroniser for a bundle of pin levels
// ---------------------------------------------------------------
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t st_ff;
  sync_t nxt_st;

  // first stage feeds only the second
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
    end
  end

  // both stages start at the pin's idle level, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= {rst_val, rst_val};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule

/* File: verification/hub_board_model.sv */
`timescale 1ns/100ps
// ----
// straps, power switches and eeprom line
// ----
module hub_board_model (
  input  wire logic       strap,
  input  wire logic [3:0] fault,
  input  wire logic       sda_low,
  input  wire logic       mode_pin_out,
  input  wire logic       mode_pin_oe_n,
  input  wire logic       port_power_enable_n,
  input  wire logic       share_pin_oe_n,
  output logic            mode_pin_in,
  output logic      [3:0] overcurrent_n,
  output logic            share_pin_in
);
  // strap resistor is only seen while the hub leaves the pin as input
  assign mode_pin_in = mode_pin_oe_n ? strap : mode_pin_out;
  // switch flags a fault low, pull-up otherwise
  assign overcurrent_n = ~fault;
  // open drain with pull-up: anyone pulling low wins
  assign share_pin_in = !(sda_low || (!share_pin_oe_n && !port_power_enable_n));
endmodule

/* File: verification/hub_pin_checker.sv */
`timescale 1ns/100ps
module hub_pin_checker #(
  parameter int STRAP_AT = 5,
  parameter int OUT_AT   = 50
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       reset_n,
  input wire logic       power_source_select,
  input wire logic       mode_pin_in,
  input wire logic       mode_pin_out,
  input wire logic       mode_pin_oe_n,
  input wire logic       global_suspend,
  input wire logic       self_powered,
  input wire logic       gang_mode,
  input wire logic [3:0] port_overcurrent,
  input wire logic       port_power_enable_n
);
  logic [20:0] age_ff;
  // cycles since reset; pin reset lags by its synchroniser
  always_ff @(posedge clk)
    if (rst || !reset_n) age_ff <= 21'h0;
    else if (ce && age_ff != 21'h1f_ffff) age_ff <= age_ff + 21'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // rules
  // ----
  sequence s_calm(sig);
    (age_ff > 15 && ce && $stable(sig))[*6];
  endsequence
  a_rst_clear: assert property ($fell(rst) |->
    mode_pin_oe_n && port_power_enable_n && !gang_mode) else $error("reset state");
  a_rstn_clear: assert property (!reset_n [*6] |-> mode_pin_oe_n && !gang_mode)
    else $error("pin reset state");
  a_self_follow: assert property (s_calm(power_source_select) |->
    self_powered == power_source_select) else $error("power source");
  a_gang_mask: assert property (gang_mode [*3] |-> port_overcurrent[3:1] == 3'h0)
    else $error("gang overcurrent");
  a_pin_gang: assert property (s_calm(global_suspend) ##0 gang_mode && !mode_pin_oe_n
    |-> mode_pin_out == global_suspend) else $error("gang pin level");
  a_pin_indiv: assert property (s_calm(global_suspend) ##0 !gang_mode && !mode_pin_oe_n
    |-> mode_pin_out == !global_suspend) else $error("individual pin level");
  a_oe_early: assert property (age_ff > 4 && !mode_pin_oe_n |-> age_ff >= OUT_AT)
    else $error("pin driven early");
  a_oe_late: assert property (age_ff == OUT_AT + 12 |-> !mode_pin_oe_n)
    else $error("pin driven late");
  a_strap_take: assert property (age_ff == STRAP_AT + 12 |-> gang_mode == mode_pin_in)
    else $error("strap not taken");
endmodule
bind hub_port_power_pin_control hub_pin_checker #(.STRAP_AT(STRAP_AT), .OUT_AT(OUT_AT)) chk (.*);

/* File: verification/tb_hub_port_power_pin_control.sv */
`timescale 1ns/100ps
module tb_hub_port_power_pin_control
  import hub_pin_pkg::*;
;
  localparam int SA = 5;
  localparam int OA = 50;
  logic        clk, rst, ce, reset_n, power_source_select, test_select, global_suspend;
  logic        eeprom_sda_out, eeprom_sda_oe_n, wr, rd, strap, sda_low, mode_pin_in;
  logic        mode_pin_out, mode_pin_oe_n, share_pin_in, port_power_enable_n, irq;
  logic        share_pin_oe_n, eeprom_sda_in, self_powered, test_mode, gang_mode, e;
  logic [3:0]  fault, overcurrent_n, port_overcurrent, addr;
  logic [31:0] wdata, rdata, v;
  int          fail_count = 0, n_checks = 0, seed = 32'h0000_53b3;
  hub_port_power_pin_control #(.STRAP_AT(SA), .OUT_AT(OA)) dut (.*);
  hub_board_model board (.*);
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----
  // helpers
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
    n_checks++;
    if (y !== x) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    cyc(1);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // gang shows suspend, individual the inverse
  function automatic logic exp_pin(input logic g, input logic s);
    return g ? s : !s;
  endfunction
  function automatic logic [3:0] exp_ovc(input logic g, input logic [3:0] f);
    return g ? {3'h0, f[0]} : f;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, far above the expected run
  initial begin
    #(3000 * 50);
    fail_count++;
    stop_test();
  end
  // ----
  // tests
  // ----
  initial begin
    {rst, ce, reset_n, eeprom_sda_out, eeprom_sda_oe_n} = 5'h1f;
    {power_source_select, test_select, global_suspend, wr, rd, strap, sda_low} = 7'h00;
    {fault, addr, wdata} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("pwr_en_n", 1'b1, port_power_enable_n);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      {strap, fault, global_suspend, reset_n} <= {!p[0], 4'h0, 2'h0};
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      cyc(SA + 14);
      chk("gang", strap, gang_mode);
      chk("oe_n", 1'b1, mode_pin_oe_n);
      cyc(OA);
      chk("oe_n", 1'b0, mode_pin_oe_n);
      for (int s = 0; s < 2; s++) begin
        @(posedge clk);
        global_suspend <= s[0];
        cyc(5);
        chk("pin", exp_pin(strap, s[0]), mode_pin_out);
      end
      for (int k = 0; k < 6; k++) begin
        @(posedge clk);
        fault <= (k == 0) ? 4'he : 4'($random(seed));
        {power_source_select, test_select} <= 2'($random(seed));
        cyc(6);
        chk("ovc", exp_ovc(strap, fault), port_overcurrent);
        chk("self", power_source_select, self_powered);
        chk("test", test_select, test_mode);
      end
      @(posedge clk);
      fault <= 4'h0;
      wr_reg(REG_MASK, 32'h0000_001f);
      wr_reg(REG_IRQ, 32'h0000_001f);
      @(posedge clk);
      fault <= 4'h2;
      cyc(6);
      chk("irq", !strap, irq);
      wr_reg(REG_MASK, 32'h0);
      chk("irq masked", 1'b0, irq);
      wr_reg(REG_IRQ, 32'h0000_001f);
      wr_reg(REG_MASK, 32'h0000_001f);
      chk("irq cleared", 1'b0, irq);
      $display("strap pass %0d done", p);
    end
    rd_reg(REG_ID, v);
    chk("id", ID_VALUE, v);
    rd_reg(4'hf, v);
    chk("unmapped", 32'h0, v);
    wr_reg(REG_CTRL, 32'h0000_0002);
    chk("pwr_en_n on", 1'b0, port_power_enable_n);
    chk("share oe_n", 1'b0, share_pin_oe_n);
    rd_reg(REG_CTRL, v);
    chk("ctrl", 32'h0000_0002, v);
    cyc(1);
    chk("rdata idle", 32'h0, rdata);
    @(posedge clk);
    ce <= 1'b0;
    power_source_select <= !self_powered;
    cyc(6);
    chk("ce hold", !power_source_select, self_powered);
    @(posedge clk);
    ce <= 1'b1;
    cyc(6);
    chk("self", power_source_select, self_powered);
    $display("control pass done");
    wr_reg(REG_CTRL, 32'h0000_0004);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      {eeprom_sda_out, eeprom_sda_oe_n, sda_low} <= 3'(k);
      cyc(4);
      chk("sda oe", eeprom_sda_oe_n, share_pin_oe_n);
      e = !(sda_low || (!eeprom_sda_oe_n && !eeprom_sda_out));
      chk("sda in", e, eeprom_sda_in);
    end
    $display("eeprom pass done");
    stop_test();
  end
endmodule
